// [logic/fps_consts.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
// clock and measuring-rate timing
`define FPS_CLK_HZ 200000000
`define FPS_RATE_STEP_HZ 100
`define FPS_ACC_WRAP (`FPS_CLK_HZ / `FPS_RATE_STEP_HZ)
`define FPS_RATE_MIN 6'h01
`define FPS_RATE_MAX 6'h3C
// peak list sizes
`define FPS_MAX_PEAKS 14
`define FPS_DIST_MAX_LAYERS 13
`define FPS_THICK_MAX_LAYERS 5
`define FPS_PCT_FULL 7'h64
// register byte offsets
`define FPS_REG_CTRL 8'h00
`define FPS_REG_RATE 8'h04
`define FPS_REG_WIN 8'h08
`define FPS_REG_THRESH 8'h0C
`define FPS_REG_LAYERS 8'h10
`define FPS_REG_EXPOSET 8'h14
`define FPS_REG_STAT 8'h18
`define FPS_REG_IRQST 8'h1C
`define FPS_REG_IRQMASK 8'h20
`define FPS_REG_LINLVL 8'h24
`define FPS_REG_PEAK0 8'h40
// interrupt status bits
`define FPS_IRQ_RESULT 0
`define FPS_IRQ_SAT 1
`define FPS_IRQ_NOPEAK 2
// reset values
`define FPS_RST_RATE 6'h0A
`define FPS_RST_WIN_END 7'h64
`define FPS_RST_THRESH 16'h0100
`define FPS_RST_LAYERS 4'h1
`define FPS_RST_EXPOSET 16'h1000
`define FPS_RST_LINLVL 16'h0800
`endif

// [logic/fps_pkg.sv]
// types shared by the peak selection block
package fps_pkg;
    // software configuration bits
    typedef struct packed {
        logic high_threshold_logic;
        logic regExpo;
        logic highest;
        logic thick;
    } fps_cfg_t;
    // one qualified peak
    typedef struct packed {
        logic [15:0] mag;
        logic [15:0] pos;
    } fps_peak_t;
    // intensity indicator codes
    typedef enum logic [1:0] {
        FPS_RED = 2'b00,
        FPS_YELLOW = 2'b01,
        FPS_GREEN = 2'b10
    } fps_int_t;
    // whole block state
    typedef struct packed {
        fps_cfg_t cfg;
        logic [5:0] rate;
        logic [6:0] winStart;
        logic [6:0] winEnd;
        logic [15:0] thresh;
        logic [3:0] layers;
        logic [15:0] expoSet;
        logic [15:0] linLevel;
        logic [20:0] acc;
        logic [15:0] bin;
        logic [15:0] m1;
        logic [15:0] m2;
        logic d1Thick;
        logic d1Dual;
        logic wSat;
        logic [3:0] wCnt;
        logic [3:0] shown;
        fps_peak_t [13:0] wList;
        fps_peak_t [13:0] pList;
        logic [3:0] pCnt;
        logic [3:0] shownLast;
        fps_int_t intensity;
        logic [15:0] expo;
        logic frameStart;
        logic resultValid;
        logic [2:0] irqSt;
        logic [2:0] irqMask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fps_state_t;
endpackage

// [logic/fps_peak_select.sv]
// peak selection and qualification of the spectrum magnitude stream
// What this block does
// [R1] rate 0.1 to 6 kHz, 100 Hz steps
// [R2] red, yellow or green intensity indicator
// [R3] results published even when intensity poor
// [R4] search limited to start/end percent window
// [R5] whole peak inside window and above threshold
// [R6] regulated mode: fixed rate, narrow exposure range
// [R7] programmable threshold drops weaker peaks
// [R8] highest peak evaluated by default
// [R9] sorting selects first or highest peaks
// [R10] distance variant: 13 layers, 14 peaks
// [R11] thickness variant: up to 5 layers in thickness mode, 13 in distance mode
// [R12] standard variant evaluates exactly one layer
// [R13] thickness order: thinnest layer first
// [R14] distance order: physical layer order
// [R15] thickness peaks shown but not evaluated
// [R16] equal-thickness shared peak counted twice
// [R17] trigger input logic standard selectable
// [R18] ordered peak list each measuring cycle
`timescale 1ns/1ps
`include "fps_consts.svh"

module fps_peak_select import fps_pkg::*; #(
    parameter int NBINS = 1024,
    parameter int VARIANT = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // spectrum stream from the front end
    input wire logic specValid,
    input wire logic [15:0] specMag,
    input wire logic specLast,
    input wire logic specSat,
    input wire logic specThick,
    input wire logic specDual,
    // measuring control and indicators
    output logic frameStart,
    output logic [15:0] exposureTime,
    output logic [1:0] intensity,
    output logic resultValid,
    output logic trigHighLevel,
    output logic irq
);
    fps_state_t q; // registered state
    fps_state_t d; // next state

    // true for any decoded register address
    function automatic logic isMapped(input logic [7:0] a);
        if (a[7:6] == 2'h1) begin
            isMapped = (a[1:0] == 2'h0) && (a[5:2] < 4'(`FPS_MAX_PEAKS));
        end else begin
            isMapped = (a[1:0] == 2'h0) && (a <= `FPS_REG_LINLVL);
        end
    endfunction

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        merge = (o & ~m) | (w & m);
    endfunction

    // peak list length allowed by variant, mode and layer count
    function automatic logic [3:0] peakLimit(input logic thick, input logic [3:0] lay);
        logic [3:0] l;
        l = (lay == 4'h0) ? 4'h1 : lay;
        if (VARIANT == 0) begin
            peakLimit = 4'h1; // R12
        end else if (thick) begin
            if (VARIANT == 2 && l > 4'(`FPS_THICK_MAX_LAYERS)) begin
                l = 4'(`FPS_THICK_MAX_LAYERS); // R11
            end else if (l > 4'(`FPS_DIST_MAX_LAYERS)) begin
                l = 4'(`FPS_DIST_MAX_LAYERS);
            end
            peakLimit = l;
        end else begin
            if (l > 4'(`FPS_DIST_MAX_LAYERS)) begin
                l = 4'(`FPS_DIST_MAX_LAYERS);
            end
            peakLimit = l + 4'h1; // R10
        end
    endfunction

    // window bounds in bins
    logic [15:0] loBin;
    logic [15:0] hiBin;
    logic [31:0] loW;
    logic [31:0] hiW;
    always_comb begin
        loW = (32'(q.winStart) * 32'(NBINS)) / 32'd100;
        hiW = (32'(q.winEnd) * 32'(NBINS)) / 32'd100;
        loBin = loW[15:0];
        hiBin = hiW[15:0];
    end

    // next-state logic
    logic [21:0] accSum;
    logic [31:0] rv;
    logic [31:0] wv;
    logic [2:0] ev;
    logic isPeak;
    logic take;
    logic [3:0] lim;
    logic [3:0] mi;
    logic [15:0] best;
    logic [15:0] stp;
    fps_peak_t pk;
    always_comb begin
        d = q;
        accSum = 22'(q.acc) + 22'(q.rate);
        rv = 32'h0000_0000;
        wv = 32'h0000_0000;
        ev = 3'h0;
        isPeak = 1'b0;
        take = 1'b0;
        lim = peakLimit(q.cfg.thick, q.layers);
        mi = 4'h0;
        best = 16'h0000;
        stp = 16'h0000;
        pk = '0;
        d.frameStart = 1'b0;
        d.resultValid = 1'b0;
        d.pready = 1'b0;
        d.pslverr = 1'b0;

        // rate divider: phase accumulator gives exact mean cycle rate
        if (accSum >= 22'(`FPS_ACC_WRAP)) begin
            d.acc = 21'(accSum - 22'(`FPS_ACC_WRAP)); // R1
            d.frameStart = 1'b1; // R18
        end else begin
            d.acc = accSum[20:0];
        end

        // spectrum stream: centre sample is the one before the current
        if (specValid) begin
            d.m1 = specMag;
            d.m2 = q.m1;
            d.d1Thick = specThick;
            d.d1Dual = specDual;
            d.bin = q.bin + 16'h0001;
            d.wSat = q.wSat | specSat;
            // local maximum with both flanks inside the window
            isPeak = (q.bin >= 16'h0002) && (q.m1 > q.m2) && (q.m1 >= specMag);
            if (isPeak && (q.m1 > q.thresh)) begin // R7
                if ((q.bin - 16'h0002 >= loBin) && (q.bin <= hiBin)) begin // R5 R4
                    if (!q.cfg.thick && q.d1Thick) begin
                        d.shown = q.shown + 4'h1; // R15
                    end else begin
                        take = 1'b1;
                    end
                end
            end
            pk.mag = q.m1;
            pk.pos = q.bin - 16'h0001;
            // list stays in bin order, i.e. thinnest or nearest first
            for (int k = 0; k < 2; k++) begin
                if (take && (k == 0 || (q.cfg.thick && q.d1Dual))) begin // R16
                    if (d.wCnt < lim) begin
                        d.wList[d.wCnt] = pk; // R13 R14
                        d.wCnt = d.wCnt + 4'h1;
                    end else if (q.cfg.highest) begin // R9
                        // drop the weakest entry, keep bin order
                        mi = 4'h0;
                        for (int j = 1; j < `FPS_MAX_PEAKS; j++) begin
                            if (4'(j) < d.wCnt && d.wList[j].mag < d.wList[mi].mag) begin
                                mi = 4'(j);
                            end
                        end
                        if (pk.mag > d.wList[mi].mag) begin // R8
                            for (int j = 0; j < `FPS_MAX_PEAKS - 1; j++) begin
                                if (4'(j) >= mi && 4'(j) + 4'h1 < d.wCnt) begin
                                    d.wList[j] = d.wList[j + 1];
                                end
                            end
                            d.wList[d.wCnt - 4'h1] = pk;
                        end
                    end
                end
            end
            // end of spectrum: publish, whatever the signal quality
            if (specLast) begin
                d.pList = d.wList; // R18
                d.pCnt = d.wCnt;
                d.shownLast = d.shown;
                d.resultValid = 1'b1; // R3
                for (int j = 0; j < `FPS_MAX_PEAKS; j++) begin
                    if (4'(j) < d.wCnt && d.wList[j].mag > best) begin
                        best = d.wList[j].mag;
                    end
                end
                // intensity indicator
                if (d.wSat || d.wCnt == 4'h0) begin
                    d.intensity = FPS_RED; // R2
                end else if (best < q.linLevel) begin
                    d.intensity = FPS_YELLOW;
                end else begin
                    d.intensity = FPS_GREEN;
                end
                ev[`FPS_IRQ_RESULT] = 1'b1;
                ev[`FPS_IRQ_SAT] = d.wSat;
                ev[`FPS_IRQ_NOPEAK] = (d.wCnt == 4'h0);
                // regulated exposure within half to full setpoint
                if (q.cfg.regExpo) begin
                    stp = q.expo >> 3;
                    if (d.wSat) begin
                        d.expo = q.expo - stp; // R6
                    end else if (best < q.linLevel) begin
                        d.expo = q.expo + stp;
                    end
                    if (d.expo > q.expoSet) begin
                        d.expo = q.expoSet;
                    end else if (d.expo < (q.expoSet >> 1)) begin
                        d.expo = q.expoSet >> 1;
                    end
                end
                d.bin = 16'h0000;
                d.wCnt = 4'h0;
                d.wSat = 1'b0;
                d.shown = 4'h0;
                d.m1 = 16'h0000;
            end
        end
        if (!q.cfg.regExpo) begin
            d.expo = q.expoSet;
        end

        // apb setup phase: read data and answer prepared
        if (psel && !penable) begin
            d.pready = 1'b1;
            if (paddr[7:6] == 2'h1) begin
                rv = q.pList[paddr[5:2]];
            end else if (paddr == `FPS_REG_CTRL) begin
                rv = 32'(q.cfg);
            end else if (paddr == `FPS_REG_RATE) begin
                rv = 32'(q.rate);
            end else if (paddr == `FPS_REG_WIN) begin
                rv = {17'h0, q.winEnd, 1'b0, q.winStart};
            end else if (paddr == `FPS_REG_THRESH) begin
                rv = 32'(q.thresh);
            end else if (paddr == `FPS_REG_LAYERS) begin
                rv = 32'(q.layers);
            end else if (paddr == `FPS_REG_EXPOSET) begin
                rv = 32'(q.expoSet);
            end else if (paddr == `FPS_REG_STAT) begin
                rv = {q.expo, 4'h0, q.shownLast, q.pCnt, 2'h0, q.intensity};
            end else if (paddr == `FPS_REG_IRQST) begin
                rv = 32'(q.irqSt);
            end else if (paddr == `FPS_REG_IRQMASK) begin
                rv = 32'(q.irqMask);
            end else if (paddr == `FPS_REG_LINLVL) begin
                rv = 32'(q.linLevel);
            end
            d.prdata = isMapped(paddr) ? rv : 32'h0000_0000;
            d.pslverr = !isMapped(paddr);
            // refuse a rate off the 100 Hz grid range
            wv = merge(32'(q.rate), pwdata, pstrb);
            if (pwrite && paddr == `FPS_REG_RATE) begin
                if (wv[31:0] < 32'(`FPS_RATE_MIN) || wv[31:0] > 32'(`FPS_RATE_MAX)) begin
                    d.pslverr = 1'b1; // R1
                end
            end
        end

        // apb access edge: writes and read-clear take effect
        d.irqSt = q.irqSt;
        if (psel && penable && q.pready && !q.pslverr) begin
            if (pwrite) begin
                if (paddr == `FPS_REG_CTRL) begin
                    wv = merge(32'(q.cfg), pwdata, pstrb);
                    d.cfg = wv[3:0]; // R9 R6 R17
                end else if (paddr == `FPS_REG_RATE) begin
                    wv = merge(32'(q.rate), pwdata, pstrb);
                    d.rate = wv[5:0];
                end else if (paddr == `FPS_REG_WIN) begin
                    wv = merge({17'h0, q.winEnd, 1'b0, q.winStart}, pwdata, pstrb);
                    d.winStart = wv[6:0]; // R4
                    d.winEnd = (wv[14:8] > `FPS_PCT_FULL) ? `FPS_PCT_FULL : wv[14:8];
                end else if (paddr == `FPS_REG_THRESH) begin
                    wv = merge(32'(q.thresh), pwdata, pstrb);
                    d.thresh = wv[15:0];
                end else if (paddr == `FPS_REG_LAYERS) begin
                    wv = merge(32'(q.layers), pwdata, pstrb);
                    d.layers = wv[3:0];
                end else if (paddr == `FPS_REG_EXPOSET) begin
                    wv = merge(32'(q.expoSet), pwdata, pstrb);
                    d.expoSet = wv[15:0];
                end else if (paddr == `FPS_REG_IRQMASK) begin
                    wv = merge(32'(q.irqMask), pwdata, pstrb);
                    d.irqMask = wv[2:0];
                end else if (paddr == `FPS_REG_LINLVL) begin
                    wv = merge(32'(q.linLevel), pwdata, pstrb);
                    d.linLevel = wv[15:0];
                end
            end else if (paddr == `FPS_REG_IRQST) begin
                // clear only what the read returned
                d.irqSt = q.irqSt & ~q.prdata[2:0];
            end
        end
        // a new event wins over a clear in the same cycle
        d.irqSt = d.irqSt | ev;
        d.irq = |(d.irqSt & d.irqMask);
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.rate <= `FPS_RST_RATE;
            q.winEnd <= `FPS_RST_WIN_END;
            q.thresh <= `FPS_RST_THRESH;
            q.layers <= `FPS_RST_LAYERS;
            q.expoSet <= `FPS_RST_EXPOSET;
            q.expo <= `FPS_RST_EXPOSET;
            q.linLevel <= `FPS_RST_LINLVL;
            q.cfg.highest <= 1'b1; // R8
            q.intensity <= FPS_RED;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign frameStart = q.frameStart;
    assign exposureTime = q.expo;
    assign intensity = q.intensity;
    assign resultValid = q.resultValid;
    assign trigHighLevel = q.cfg.high_threshold_logic; // R17
    assign irq = q.irq;
endmodule

// [sim/fps_peak_select_monitor.sv]
// concurrent checks on the ports of the peak selection block
`timescale 1ns/1ps
module fps_peak_select_monitor import fps_pkg::*; #(
    parameter int NBINS = 1024,
    parameter int VARIANT = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // stream and indicators
    input wire logic specValid,
    input wire logic specLast,
    input wire logic specSat,
    input wire logic frameStart,
    input wire logic [1:0] intensity,
    input wire logic resultValid,
    input wire logic trigHighLevel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [16:0] gap_q; // edges since the last frame start
    logic seen_q; // one frame start already seen
    logic wrCtrl; // completed write to the control word
    assign wrCtrl = psel && penable && pready && pwrite && (paddr == 8'h00);
    // frame spacing counter, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 17'h00000;
            seen_q <= 1'b0;
        end else if (frameStart) begin
            gap_q <= 17'h00001;
            seen_q <= 1'b1;
        end else if (gap_q != 17'h1FFFF) begin
            gap_q <= gap_q + 17'h00001;
        end
    end
    property p_ready_answer;
        psel && !penable |=> pready;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("pready late after setup");
    property p_ready_once;
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr outside access cycle");
    property p_result_after_last;
        specValid && specLast |=> resultValid;
    endproperty
    a_result_after_last: assert property (p_result_after_last) else $error("result missing");
    property p_result_cause;
        resultValid |-> $past(specValid && specLast);
    endproperty
    a_result_cause: assert property (p_result_cause) else $error("result without spectrum");
    property p_int_code;
        intensity != 2'b11;
    endproperty
    a_int_code: assert property (p_int_code) else $error("illegal intensity code");
    property p_int_update;
        $changed(intensity) |-> resultValid;
    endproperty
    a_int_update: assert property (p_int_update) else $error("intensity moved off result");
    property p_sat_red;
        specValid && specLast && specSat |=> intensity == FPS_RED;
    endproperty
    a_sat_red: assert property (p_sat_red) else $error("saturated frame not red");
    property p_trig_cause;
        $changed(trigHighLevel) |-> $past(wrCtrl) || $past(wrCtrl, 2);
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger level moved alone");
    property p_frame_gap;
        frameStart && seen_q |-> gap_q >= 17'h08235;
    endproperty
    a_frame_gap: assert property (p_frame_gap) else $error("frames closer than fastest rate");
    c_result: cover property (resultValid);
    c_refused: cover property (pslverr);
    c_sat: cover property (specValid && specSat && specLast);
    c_gap: cover property (frameStart && seen_q);
endmodule

bind fps_peak_select fps_peak_select_monitor #(.NBINS(NBINS), .VARIANT(VARIANT)) u_mon (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .specValid,
    .specLast, .specSat, .frameStart, .intensity, .resultValid, .trigHighLevel
);

// [sim/fps_front_end_model.sv]
// spectrum source standing in for the optical front end
`timescale 1ns/1ps
module fps_front_end_model #(
    parameter int NBINS = 32
) (
    // clock
    input wire logic clk,
    // spectrum stream
    output logic specValid = 1'b0,
    output logic [15:0] specMag = 16'h5A5A,
    output logic specLast = 1'b0,
    output logic specSat = 1'b0,
    output logic specThick = 1'b0,
    output logic specDual = 1'b0
);
    logic [15:0] mag [NBINS]; // magnitude per bin
    logic [NBINS-1:0] sat; // saturated bins
    logic [NBINS-1:0] thick; // thickness peak bins
    logic [NBINS-1:0] dual; // shared equal-thickness bins
    logic go = 1'b0; // frame requested
    int bin = -1; // bin on the stream, negative when idle
    // one bin per clock inside a frame; toggling junk outside it
    always @(posedge clk) begin
        if (bin >= 0) begin
            specValid <= 1'b1;
            specMag <= mag[bin];
            specLast <= (bin == NBINS - 1);
            specSat <= sat[bin];
            specThick <= thick[bin];
            specDual <= dual[bin];
            bin <= (bin == NBINS - 1) ? -1 : bin + 1;
        end else begin
            specValid <= 1'b0;
            specMag <= ~specMag;
            specLast <= ~specLast;
            specSat <= ~specSat;
            specThick <= ~specThick;
            specDual <= ~specDual;
            if (go) begin
                go = 1'b0;
                bin <= 0;
            end
        end
    end
    // empty spectrum
    task automatic clear();
        foreach (mag[k]) mag[k] = 16'h0000;
        sat = '0;
        thick = '0;
        dual = '0;
    endtask
    // send one whole spectrum and return once its last bin is on the stream
    task automatic send_frame();
        @(negedge clk);
        go = 1'b1;
        @(negedge clk);
        while (go || bin >= 0) @(negedge clk);
    endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the peak selection block
`timescale 1ns/1ps
module tb;
    localparam int NB = 32; // short spectrum keeps frames brief
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rv;
    logic pready, pslverr, specValid, specLast, specSat, specThick, specDual;
    logic frameStart, resultValid, trigHighLevel, irq;
    logic [15:0] specMag, exposureTime;
    logic [1:0] intensity;
    int error_cnt = 0;
    int checks_done = 0;
    int i;
    // reset map: address and value
    logic [7:0] rstA [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                              8'h20, 8'h24};
    logic [31:0] rstV [10] = '{32'h2, 32'hA, 32'h6400, 32'h100, 32'h1, 32'h1000,
                               32'h10000000, 32'h0, 32'h0, 32'h800};
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    fps_peak_select #(.NBINS(NB), .VARIANT(1)) u_dut (
        .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
        .pready, .pslverr, .specValid, .specMag, .specLast, .specSat, .specThick, .specDual,
        .frameStart, .exposureTime, .intensity, .resultValid, .trigHighLevel, .irq
    );
    fps_front_end_model #(.NBINS(NB)) u_fe (
        .clk, .specValid, .specMag, .specLast, .specSat, .specThick, .specDual
    );
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rv = prdata;
        check("pready pslverr", {pready, pslverr}, {1'b1, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // read a register and compare
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        check($sformatf("reg %h", a), rv, exp);
    endtask
    // one spectrum, then wait for its result pulse
    task automatic frame();
        int n = 0;
        u_fe.send_frame();
        do begin
            @(posedge clk);
            n++;
        end while (resultValid !== 1'b1 && n < 10);
        check("resultValid", resultValid, 1'b1);
    endtask
    // verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog against a hung wait
    initial begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    // test sequence
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 10; i++) rc(rstA[i], rstV[i]);
        apb(1'b0, 8'h30, 32'h0, 1'b1); // unmapped address refused
        check("unmapped data", rv, 32'h0);
        apb(1'b0, 8'h02, 32'h0, 1'b1); // misaligned address refused
        $display("test reset done");
        u_fe.clear();
        u_fe.mag[5] = 16'h0300;
        u_fe.mag[10] = 16'h0900;
        u_fe.mag[15] = 16'h0080;
        u_fe.mag[20] = 16'h0500;
        frame();
        rc(8'h18, 32'h10000022);
        rc(8'h40, 32'h0900000A);
        rc(8'h44, 32'h05000014);
        rc(8'h1C, 32'h1);
        rc(8'h1C, 32'h0);
        check("irq masked", irq, 1'b0);
        $display("test highest done");
        apb(1'b1, 8'h00, 32'h0, 1'b0); // first-peak sorting
        apb(1'b1, 8'h20, 32'h1, 1'b0); // unmask result event
        frame();
        rc(8'h40, 32'h03000005);
        rc(8'h44, 32'h0900000A);
        check("irq raised", irq, 1'b1);
        rc(8'h1C, 32'h1);
        repeat (2) @(posedge clk);
        check("irq cleared", irq, 1'b0);
        $display("test first done");
        u_fe.thick[20] = 1'b1;
        apb(1'b1, 8'h10, 32'h2, 1'b0); // three distance peaks allowed
        frame();
        rc(8'h18, 32'h10000122);
        u_fe.thick[20] = 1'b0;
        u_fe.dual[10] = 1'b1;
        apb(1'b1, 8'h00, 32'h1, 1'b0); // thickness mode, first sorting
        apb(1'b1, 8'h10, 32'h3, 1'b0);
        frame();
        rc(8'h18, 32'h10000032);
        rc(8'h40, 32'h03000005);
        rc(8'h48, 32'h0900000A);
        $display("test layers done");
        u_fe.dual[10] = 1'b0;
        apb(1'b1, 8'h00, 32'h0, 1'b0);
        apb(1'b1, 8'h10, 32'h1, 1'b0);
        apb(1'b1, 8'h0C, 32'h40, 1'b0);
        apb(1'b1, 8'h08, 32'h3219, 1'b0); // window 25 to 50 percent
        frame();
        rc(8'h18, 32'h10000022);
        rc(8'h44, 32'h0080000F);
        apb(1'b1, 8'h08, 32'h2F19, 1'b0); // end bound on the peak bin, one bin short of its right flank
        frame();
        rc(8'h18, 32'h10000012);
        apb(1'b1, 8'h08, 32'h6400, 1'b0);
        apb(1'b1, 8'h0C, 32'h900, 1'b0); // threshold equal to the best peak
        frame();
        rc(8'h18, 32'h10000000);
        rc(8'h1C, 32'h5);
        $display("test window done");
        apb(1'b1, 8'h0C, 32'h100, 1'b0);
        apb(1'b1, 8'h24, 32'hA00, 1'b0); // linearity level above best peak
        frame();
        rc(8'h18, 32'h10000021);
        apb(1'b1, 8'h24, 32'h800, 1'b0);
        apb(1'b1, 8'h00, 32'h4, 1'b0); // regulated exposure
        u_fe.sat[NB-1] = 1'b1;
        frame();
        rc(8'h18, 32'h0E000020);
        check("exposure", exposureTime, 16'h0E00);
        check("intensity", intensity, 2'h0);
        rc(8'h04, 32'hA);
        rc(8'h1C, 32'h3);
        $display("test intensity done");
        u_fe.clear();
        for (i = 0; i < 15; i++) u_fe.mag[2 * i + 1] = 16'h0200;
        apb(1'b1, 8'h00, 32'h0, 1'b0);
        apb(1'b1, 8'h10, 32'hD, 1'b0); // thirteen layers
        frame();
        rc(8'h18, 32'h100000E1);
        rc(8'h74, 32'h0200001B);
        $display("test peak count done");
        apb(1'b1, 8'h04, 32'h0, 1'b1);
        apb(1'b1, 8'h04, 32'h3D, 1'b1);
        apb(1'b1, 8'h04, 32'h3C, 1'b0);
        rc(8'h04, 32'h3C);
        apb(1'b1, 8'h00, 32'h8, 1'b0);
        @(posedge clk);
        check("trigger level", trigHighLevel, 1'b1);
        repeat (2) begin
            i = 0;
            do begin
                @(posedge clk);
                i++;
            end while (frameStart !== 1'b1 && i < 40000);
        end
        check("frame gap", (i == 33333) || (i == 33334), 1'b1);
        $display("test rate done");
        final_report();
    end
endmodule
